/* File: core/chgseq_pkg.sv */
// constants, types and timing for the charger control sequencer
//
// Behaviour
// R1: a fresh charge cycle starts only after power-on reset or battery reinsertion; code also starts one on resume and from idle
// R2: battery 5% over target turns buck off and battery FET on
// R3: meeting termination launches battery presence detection before charge done
// R4: sink phase held above presence level for full interval means charge done
// R5: drop below level starts source phase, stopped at level, then sink again
// R6: detection alternates until charging disabled or battery found, then new cycle
// R7: with termination disabled no presence detection is run
// R8: source present and device enabled starts buck; charge enable starts a cycle
// R9: battery above 3.5 V turns battery FET fully on
// R10: path loop at zero current with rising load enters supplement, FET on
// R11: path loop reducing current runs the safety timer at half rate
// R12: target below battery voltage turns FET off, load rail at FET-off level
// R13: USB selector codes decode to fixed input limits and droop thresholds
// R14: both low selector bits high means high impedance, buck shut down
// R15: lowest USB limit selected disables charge termination
// R16: input with more power wins; isolated inputs; over-voltage input ignored
// R17: battery-only short limit turns FET off for deglitch time, then retries
// R18: discharge gate driven with no valid supply or all USB selectors high
// R19: charging starts a 6 hour timer; expiry ends cycle with FET off
// R20: timer fault clears only on resume, power-on reset or battery swap
// R21: in fast charge listed limiting conditions halve the timer rate
// R22: timer resets on new cycle, selector toggle resume or thermal shutdown
// R23: charge selector codes: normal, half current, 4.06 V target, suspended
// R24: termination needs recharge level, low current, no supplement, for 32 ms
// R25: safety timer counts slow ticks, only alternate ticks when half rate
package chgseq_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;

  // termination deglitch
  localparam int unsigned TERM_DEGLITCH_MS = 32;
  localparam int unsigned TERM_CYC = CLK_HZ / 1000 * TERM_DEGLITCH_MS;

  // presence check interval
  localparam int unsigned DETECT_MS = 250;
  localparam int unsigned DETECT_CYC = CLK_HZ / 1000 * DETECT_MS;

  // battery-only short deglitch
  localparam int unsigned SHORT_DEGLITCH_US = 64;
  localparam int unsigned SHORT_CYC = CLK_HZ / 1_000_000 * SHORT_DEGLITCH_US;

  // safety timer slow tick and length
  localparam int unsigned TICK_MS = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned SAFETY_HOURS = 6;
  localparam int unsigned SAFETY_TICKS = SAFETY_HOURS * 3600 * 1000 / TICK_MS;

  localparam int unsigned CNT_W = 25;
  localparam int unsigned TMR_W = 16;

  // usb selector codes {sel2, sel1, sel0}
  localparam logic [2:0] USB_SEL_100 = 3'h0;
  localparam logic [2:0] USB_SEL_500 = 3'h1;
  localparam logic [2:0] USB_SEL_1500 = 3'h2;
  localparam logic [2:0] USB_SEL_150 = 3'h4;
  localparam logic [2:0] USB_SEL_900 = 3'h5;
  localparam logic [2:0] USB_SEL_800 = 3'h6;
  localparam logic [2:0] USB_SEL_ALL = 3'h7;

  // usb input limits in mA
  localparam logic [11:0] LIM_100_MA = 12'h064;
  localparam logic [11:0] LIM_500_MA = 12'h1f4;
  localparam logic [11:0] LIM_1500_MA = 12'h5dc;
  localparam logic [11:0] LIM_150_MA = 12'h096;
  localparam logic [11:0] LIM_900_MA = 12'h384;
  localparam logic [11:0] LIM_800_MA = 12'h320;
  localparam logic [11:0] LIM_OFF_MA = 12'h000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CHARGE = 3'h1,
    ST_SINK = 3'h2,
    ST_SOURCE = 3'h3,
    ST_DONE = 3'h4,
    ST_FAULT = 3'h5
  } chgseq_state_t;

endpackage : chgseq_pkg

/* File: core/chgseq_delay.sv */
// interval counter: done rises after LIMIT edges of continuous run
`timescale 1ns/10ps
module chgseq_delay #(
  parameter int unsigned CW = 25,
  parameter logic [CW-1:0] LIMIT = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  output logic done
);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic done;
  } chgseq_dly_t;

  chgseq_dly_t s_r;
  chgseq_dly_t s_nxt;

  // any gap in run restarts the interval from zero
  always_comb begin
    s_nxt = s_r;
    if (!run) begin
      s_nxt.cnt = '0;
      s_nxt.done = 1'b0;
    end else if (!s_r.done) begin
      if (s_r.cnt >= LIMIT - 1'b1) begin
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done = s_r.done;

endmodule : chgseq_delay

/* File: core/chgseq_top.sv */
// charge cycle sequencer, presence detection, input selection and safety timer
`timescale 1ns/10ps
module chgseq_top #(
  parameter int unsigned TERM_CYC = chgseq_pkg::TERM_CYC,
  parameter int unsigned DETECT_CYC = chgseq_pkg::DETECT_CYC,
  parameter int unsigned SHORT_CYC = chgseq_pkg::SHORT_CYC,
  parameter int unsigned TICK_CYC = chgseq_pkg::TICK_CYC,
  parameter int unsigned SAFETY_TICKS = chgseq_pkg::SAFETY_TICKS
) (
  input wire logic CLK,
  input wire logic RESET_N,
  // supplies
  input wire logic IN_VALID,
  input wire logic IN_OVP,
  input wire logic USB_VALID,
  input wire logic USB_OVP,
  input wire logic DEVICE_EN,
  // host pins
  input wire logic CHARGE_SELECT_A_N,
  input wire logic CHARGE_SELECT_B_N,
  input wire logic USB_LIMIT_SEL0,
  input wire logic USB_LIMIT_SEL1,
  input wire logic USB_LIMIT_SEL2,
  // battery comparators
  input wire logic BAT_CONNECTED,
  input wire logic BAT_ABOVE_PRESENCE,
  input wire logic BAT_ABOVE_3V5,
  input wire logic BAT_ABOVE_RECHARGE,
  input wire logic BAT_ABOVE_TARGET,
  input wire logic BAT_OVER_LIMIT,
  input wire logic BAT_BELOW_SHORT,
  input wire logic CHG_BELOW_TERM,
  input wire logic SHORT_LIMIT_HIT,
  // regulation loop status
  input wire logic PATH_LOOP_ACTIVE,
  input wire logic SUPPLEMENT_REQ,
  input wire logic INPUT_LIMIT_ACTIVE,
  input wire logic THERMAL_REG_ACTIVE,
  input wire logic THERMAL_SHUTDOWN,
  input wire logic THERM_WARM_COLD,
  // outputs
  output logic BUCK_EN,
  output logic BAT_FET_ON,
  output logic RAIL_FET_OFF_REG,
  output logic CHARGE_ON,
  output logic HALF_CURRENT,
  output logic TARGET_REDUCED,
  output logic PRESENCE_SINK_EN,
  output logic PRESENCE_SOURCE_EN,
  output logic SELECT_IN,
  output logic SELECT_USB,
  output logic [11:0] USB_LIMIT_MA,
  output logic USB_DROOP_HIGH,
  output logic TERM_ENABLED,
  output logic DISCHARGE_GATE_DRIVE,
  output logic CHARGE_DONE,
  output logic TIMER_FAULT
);

  localparam int unsigned CW = chgseq_pkg::CNT_W;
  localparam int unsigned TW = chgseq_pkg::TMR_W;

  typedef struct packed {
    chgseq_pkg::chgseq_state_t state;
    logic [CW-1:0] tick_cnt;
    logic tick_phase;
    logic [TW-1:0] safety_cnt;
    logic det_restart;
    logic short_off;
    logic chg_allowed_d;
    logic hiz_d;
    logic bat_conn_d;
    logic timer_fault;
    logic buck_en;
    logic bat_fet_on;
    logic rail_fet_off;
    logic charge_on;
    logic half_cur;
    logic target_low;
    logic sink_en;
    logic source_en;
    logic sel_in;
    logic sel_usb;
    logic [11:0] usb_ma;
    logic droop_high;
    logic term_en;
    logic gate_drive;
    logic chg_done;
  } chgseq_st_t;

  chgseq_st_t s_r;
  chgseq_st_t s_nxt;

  logic [2:0] usb_sel;
  logic in_ok;
  logic usb_ok;
  logic src_ok;
  logic hiz;
  logic chg_allowed;
  logic buck_ok;
  logic term_ok;
  logic half_rate;
  logic in_det;
  logic term_run;
  logic det_run;
  logic term_done;
  logic det_done;
  logic short_done;
  logic new_cycle;
  logic resume;
  logic tick;
  logic expired;

  // input decode
  assign usb_sel = {USB_LIMIT_SEL2, USB_LIMIT_SEL1, USB_LIMIT_SEL0};
  // an over-voltage input is simply not a candidate
  assign in_ok = IN_VALID & ~IN_OVP; // R16
  assign usb_ok = USB_VALID & ~USB_OVP; // R16
  assign src_ok = in_ok | usb_ok;
  assign hiz = USB_LIMIT_SEL0 & USB_LIMIT_SEL1; // R14
  // both selectors high suspends charging, buck keeps running
  assign chg_allowed = ~(CHARGE_SELECT_A_N & CHARGE_SELECT_B_N); // R23
  assign buck_ok = src_ok & DEVICE_EN & ~hiz & ~BAT_OVER_LIMIT & ~THERMAL_SHUTDOWN; // R8 R14 R2
  assign term_ok = usb_sel != chgseq_pkg::USB_SEL_100; // R15

  // any limiting condition slows the safety timer
  assign half_rate = PATH_LOOP_ACTIVE | INPUT_LIMIT_ACTIVE | THERMAL_REG_ACTIVE // R11 R21
    | (CHARGE_SELECT_A_N ^ CHARGE_SELECT_B_N) | BAT_BELOW_SHORT | THERM_WARM_COLD; // R21

  // cycle start events
  assign new_cycle = BAT_CONNECTED & ~s_r.bat_conn_d; // R1
  assign resume = (chg_allowed & ~s_r.chg_allowed_d) | (~hiz & s_r.hiz_d); // R20

  // termination window, broken by supplement events
  assign term_run = (s_r.state == chgseq_pkg::ST_CHARGE) & BAT_ABOVE_RECHARGE // R24
    & CHG_BELOW_TERM & ~SUPPLEMENT_REQ & term_ok; // R24

  // presence phase interval restarts on each phase change
  assign in_det = (s_r.state == chgseq_pkg::ST_SINK) | (s_r.state == chgseq_pkg::ST_SOURCE);
  assign det_run = in_det & ~s_r.det_restart;

  assign tick = s_r.tick_cnt == CW'(TICK_CYC - 1);
  assign expired = s_r.safety_cnt >= TW'(SAFETY_TICKS);

  chgseq_delay #(
    .CW(CW),
    .LIMIT(CW'(TERM_CYC))
  ) u_term_dly (
    .clk(CLK),
    .rst_n(RESET_N),
    .run(term_run),
    .done(term_done)
  );

  chgseq_delay #(
    .CW(CW),
    .LIMIT(CW'(DETECT_CYC))
  ) u_det_dly (
    .clk(CLK),
    .rst_n(RESET_N),
    .run(det_run),
    .done(det_done)
  );

  chgseq_delay #(
    .CW(CW),
    .LIMIT(CW'(SHORT_CYC))
  ) u_short_dly (
    .clk(CLK),
    .rst_n(RESET_N),
    .run(s_r.short_off),
    .done(short_done)
  );

  // next state of everything
  always_comb begin
    s_nxt = s_r;
    s_nxt.chg_allowed_d = chg_allowed;
    s_nxt.hiz_d = hiz;
    s_nxt.bat_conn_d = BAT_CONNECTED;
    s_nxt.det_restart = 1'b0;

    // slow tick runs freely, only counted while charging or in the presence sink and source phases
    if (tick) begin
      s_nxt.tick_cnt = '0;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;
    end
    if (tick && (s_r.state == chgseq_pkg::ST_CHARGE || in_det) && !expired) begin
      if (half_rate) begin
        s_nxt.tick_phase = ~s_r.tick_phase; // R25
        if (s_r.tick_phase) begin
          s_nxt.safety_cnt = s_r.safety_cnt + 1'b1; // R11 R21
        end
      end else begin
        s_nxt.safety_cnt = s_r.safety_cnt + 1'b1; // R25
      end
    end

    // sequencer; thermal shutdown and cycle events take priority
    if (THERMAL_SHUTDOWN) begin
      s_nxt.state = chgseq_pkg::ST_IDLE;
      s_nxt.safety_cnt = '0; // R22
      s_nxt.tick_phase = 1'b0;
    end else if (new_cycle || resume) begin
      // battery found or host resume: fault clears, fresh timer
      s_nxt.timer_fault = 1'b0; // R6 R20
      s_nxt.safety_cnt = '0; // R22
      s_nxt.tick_phase = 1'b0;
      if (buck_ok && chg_allowed) begin
        s_nxt.state = chgseq_pkg::ST_CHARGE; // R1
      end else begin
        s_nxt.state = chgseq_pkg::ST_IDLE;
      end
    end else begin
      case (s_r.state)
        chgseq_pkg::ST_IDLE: begin
          if (buck_ok && chg_allowed) begin
            s_nxt.state = chgseq_pkg::ST_CHARGE; // R8
            s_nxt.safety_cnt = '0; // R19
            s_nxt.tick_phase = 1'b0;
          end
        end
        chgseq_pkg::ST_CHARGE: begin
          if (!buck_ok || !chg_allowed) begin
            s_nxt.state = chgseq_pkg::ST_IDLE;
          end else if (expired) begin
            s_nxt.state = chgseq_pkg::ST_FAULT; // R19
            s_nxt.timer_fault = 1'b1; // R19
          end else if (term_done) begin
            // term_done cannot rise with termination disabled
            s_nxt.state = chgseq_pkg::ST_SINK; // R3 R7
            s_nxt.det_restart = 1'b1;
          end
        end
        chgseq_pkg::ST_SINK: begin
          if (!buck_ok || !chg_allowed) begin
            s_nxt.state = chgseq_pkg::ST_IDLE; // R6
          end else if (!BAT_ABOVE_PRESENCE) begin
            s_nxt.state = chgseq_pkg::ST_SOURCE; // R5
            s_nxt.det_restart = 1'b1;
          end else if (det_done) begin
            s_nxt.state = chgseq_pkg::ST_DONE; // R4
          end
        end
        chgseq_pkg::ST_SOURCE: begin
          if (!buck_ok || !chg_allowed) begin
            s_nxt.state = chgseq_pkg::ST_IDLE; // R6
          end else if (det_done) begin
            s_nxt.state = chgseq_pkg::ST_SINK; // R5 R6
            s_nxt.det_restart = 1'b1;
          end
        end
        chgseq_pkg::ST_DONE: begin
          // recharge once the battery sags below the recharge level
          if (!BAT_ABOVE_RECHARGE && buck_ok && chg_allowed) begin
            s_nxt.state = chgseq_pkg::ST_CHARGE;
            s_nxt.safety_cnt = '0;
            s_nxt.tick_phase = 1'b0;
          end
        end
        chgseq_pkg::ST_FAULT: begin
          // held until resume, reset, battery swap or thermal shutdown
          s_nxt.state = chgseq_pkg::ST_FAULT; // R20
        end
        default: begin
          s_nxt.state = chgseq_pkg::ST_IDLE;
        end
      endcase
    end

    // battery-only short retry: off for deglitch, then try again
    if (s_r.short_off) begin
      if (short_done) begin
        s_nxt.short_off = 1'b0; // R17
      end
    end else if (!buck_ok && SHORT_LIMIT_HIT) begin
      s_nxt.short_off = 1'b1; // R17
    end

    // battery FET, over-voltage discharge wins over everything
    if (BAT_OVER_LIMIT) begin
      s_nxt.bat_fet_on = 1'b1; // R2
    end else if (s_nxt.state == chgseq_pkg::ST_FAULT) begin
      s_nxt.bat_fet_on = 1'b0; // R19
    end else if (s_nxt.short_off) begin
      s_nxt.bat_fet_on = 1'b0; // R17
    end else if (BAT_ABOVE_TARGET && buck_ok) begin
      s_nxt.bat_fet_on = 1'b0; // R12
    end else begin
      s_nxt.bat_fet_on = BAT_ABOVE_3V5 | SUPPLEMENT_REQ | ~buck_ok; // R9 R10 R17
    end
    s_nxt.rail_fet_off = BAT_ABOVE_TARGET & buck_ok & ~BAT_OVER_LIMIT; // R12

    // power stage and charge controls
    s_nxt.buck_en = buck_ok; // R8 R2 R14
    s_nxt.sel_in = buck_ok & in_ok; // R16
    s_nxt.sel_usb = buck_ok & ~in_ok & usb_ok; // R16
    s_nxt.charge_on = s_nxt.state == chgseq_pkg::ST_CHARGE;
    s_nxt.half_cur = ~CHARGE_SELECT_A_N & CHARGE_SELECT_B_N; // R23
    s_nxt.target_low = CHARGE_SELECT_A_N & ~CHARGE_SELECT_B_N; // R23
    s_nxt.sink_en = s_nxt.state == chgseq_pkg::ST_SINK; // R4
    // source stops as soon as the level is reached
    s_nxt.source_en = (s_nxt.state == chgseq_pkg::ST_SOURCE) & ~BAT_ABOVE_PRESENCE; // R5
    s_nxt.chg_done = s_nxt.state == chgseq_pkg::ST_DONE;
    s_nxt.term_en = term_ok; // R15
    s_nxt.gate_drive = ~src_ok | (usb_sel == chgseq_pkg::USB_SEL_ALL); // R18

    // usb limit table
    case (usb_sel)
      chgseq_pkg::USB_SEL_100: begin
        s_nxt.usb_ma = chgseq_pkg::LIM_100_MA; // R13
        s_nxt.droop_high = 1'b0;
      end
      chgseq_pkg::USB_SEL_500: begin
        s_nxt.usb_ma = chgseq_pkg::LIM_500_MA; // R13
        s_nxt.droop_high = 1'b1;
      end
      chgseq_pkg::USB_SEL_1500: begin
        s_nxt.usb_ma = chgseq_pkg::LIM_1500_MA; // R13
        s_nxt.droop_high = 1'b1;
      end
      chgseq_pkg::USB_SEL_150: begin
        s_nxt.usb_ma = chgseq_pkg::LIM_150_MA; // R13
        s_nxt.droop_high = 1'b0;
      end
      chgseq_pkg::USB_SEL_900: begin
        s_nxt.usb_ma = chgseq_pkg::LIM_900_MA; // R13
        s_nxt.droop_high = 1'b1;
      end
      chgseq_pkg::USB_SEL_800: begin
        s_nxt.usb_ma = chgseq_pkg::LIM_800_MA; // R13
        s_nxt.droop_high = 1'b1;
      end
      default: begin
        // high impedance codes: no usb draw at all
        s_nxt.usb_ma = chgseq_pkg::LIM_OFF_MA; // R14
        s_nxt.droop_high = 1'b0;
      end
    endcase
  end

  // single state register; edge history cleared, so a battery
  // present at reset is seen as an insertion and starts a cycle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign BUCK_EN = s_r.buck_en;
  assign BAT_FET_ON = s_r.bat_fet_on;
  assign RAIL_FET_OFF_REG = s_r.rail_fet_off;
  assign CHARGE_ON = s_r.charge_on;
  assign HALF_CURRENT = s_r.half_cur;
  assign TARGET_REDUCED = s_r.target_low;
  assign PRESENCE_SINK_EN = s_r.sink_en;
  assign PRESENCE_SOURCE_EN = s_r.source_en;
  assign SELECT_IN = s_r.sel_in;
  assign SELECT_USB = s_r.sel_usb;
  assign USB_LIMIT_MA = s_r.usb_ma;
  assign USB_DROOP_HIGH = s_r.droop_high;
  assign TERM_ENABLED = s_r.term_en;
  assign DISCHARGE_GATE_DRIVE = s_r.gate_drive;
  assign CHARGE_DONE = s_r.chg_done;
  assign TIMER_FAULT = s_r.timer_fault;

endmodule : chgseq_top

/* File: testbench/chgseq_properties.sv */
// assertion checker on the sequencer top ports
`timescale 1ns/10ps
module chgseq_properties #(
  parameter int unsigned TERM_CYC = 1,
  parameter int unsigned DETECT_CYC = 1,
  parameter int unsigned SHORT_CYC = 1,
  parameter int unsigned TICK_CYC = 1,
  parameter int unsigned SAFETY_TICKS = 1
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic IN_VALID,
  input wire logic IN_OVP,
  input wire logic USB_VALID,
  input wire logic USB_OVP,
  input wire logic DEVICE_EN,
  input wire logic USB_LIMIT_SEL0,
  input wire logic USB_LIMIT_SEL1,
  input wire logic USB_LIMIT_SEL2,
  input wire logic BAT_OVER_LIMIT,
  input wire logic BAT_ABOVE_PRESENCE,
  input wire logic BUCK_EN,
  input wire logic BAT_FET_ON,
  input wire logic SELECT_IN,
  input wire logic SELECT_USB,
  input wire logic [11:0] USB_LIMIT_MA,
  input wire logic USB_DROOP_HIGH,
  input wire logic TERM_ENABLED,
  input wire logic DISCHARGE_GATE_DRIVE,
  input wire logic PRESENCE_SINK_EN,
  input wire logic PRESENCE_SOURCE_EN,
  input wire logic CHARGE_ON,
  input wire logic CHARGE_DONE,
  input wire logic TIMER_FAULT
);
  logic [1:0] age_r;
  logic [2:0] sel;
  logic [12:0] dec;
  logic live;
  logic in_ok;
  logic usb_ok;
  logic pick;

  // shared input decodes
  assign sel = {USB_LIMIT_SEL2, USB_LIMIT_SEL1, USB_LIMIT_SEL0};
  assign in_ok = IN_VALID && !IN_OVP;
  assign usb_ok = USB_VALID && !USB_OVP;
  // battery over-voltage stops the buck, so no input is in use then
  assign pick = DEVICE_EN && sel[1:0] != 2'h3 && !BAT_OVER_LIMIT;
  assign live = age_r == 2'h3;

  // outputs lag inputs by a flop, so skip the edges right after reset
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      age_r <= 2'h0;
    end else if (!live) begin
      age_r <= age_r + 2'h1;
    end
  end

  // expected {droop, limit in mA}; hiz codes give zero
  always_comb begin
    case (sel)
      3'h0: dec = {1'b0, 12'h064};
      3'h1: dec = {1'b1, 12'h1f4};
      3'h2: dec = {1'b1, 12'h5dc};
      3'h4: dec = {1'b0, 12'h096};
      3'h5: dec = {1'b1, 12'h384};
      3'h6: dec = {1'b1, 12'h320};
      default: dec = 13'h0000;
    endcase
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  a_limit_decode: assert property (live |-> {USB_DROOP_HIGH, USB_LIMIT_MA} == $past(dec))
    else $error("usb limit decode wrong");
  a_hiz_buck_off: assert property (live && $past(sel[1:0] == 2'h3) |-> !BUCK_EN)
    else $error("buck running in hiz");
  a_low_no_term: assert property (live && $past(sel == 3'h0) |-> !TERM_ENABLED)
    else $error("termination on at lowest limit");
  a_gate_drive: assert property (live |-> DISCHARGE_GATE_DRIVE == $past(!(in_ok || usb_ok) || sel == 3'h7))
    else $error("discharge gate wrong");
  a_in_wins: assert property (live && $past(in_ok && pick) |-> SELECT_IN && !SELECT_USB)
    else $error("main input not preferred");
  a_usb_fallback: assert property (live && $past(!in_ok && usb_ok && pick) |-> SELECT_USB && !SELECT_IN)
    else $error("valid usb not used");
  a_overv_fet_on: assert property (live && $past(BAT_OVER_LIMIT) |-> BAT_FET_ON && !BUCK_EN)
    else $error("over-voltage response wrong");
  a_detect_needs_term: assert property ($rose(PRESENCE_SINK_EN) && $past(CHARGE_ON) |-> $past(TERM_ENABLED))
    else $error("detection without termination");
  a_sink_to_source: assert property (PRESENCE_SINK_EN && !BAT_ABOVE_PRESENCE |-> ##1 !PRESENCE_SINK_EN && !CHARGE_DONE)
    else $error("sink held after drop");
  a_done_from_sink: assert property ($rose(CHARGE_DONE) |-> $past(PRESENCE_SINK_EN) && $past(BAT_ABOVE_PRESENCE, 2))
    else $error("done without passing sink");
  a_fault_fet_off: assert property (live && TIMER_FAULT && !$past(BAT_OVER_LIMIT) |-> !BAT_FET_ON)
    else $error("fet on during timer fault");

  c_done: cover property ($rose(CHARGE_DONE));
  c_fault: cover property ($rose(TIMER_FAULT));
  c_source: cover property ($rose(PRESENCE_SOURCE_EN));
endmodule : chgseq_properties

/* File: testbench/chgseq_battery_model.sv */
// battery stand-in answering the presence sink and source phases
`timescale 1ns/10ps
module chgseq_battery_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic present,
  input wire logic sink_en,
  input wire logic source_en,
  output logic above
);
  logic [1:0] lvl_r;

  // an absent cell sags under the sink and climbs back under the source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_r <= 2'h3;
    end else if (sink_en && lvl_r != 2'h0) begin
      lvl_r <= lvl_r - 2'h1;
    end else if (source_en && lvl_r != 2'h3) begin
      lvl_r <= lvl_r + 2'h1;
    end
  end
  assign above = present || lvl_r == 2'h3;
endmodule : chgseq_battery_model

/* File: testbench/testbench.sv */
// self-checking bench for the charger control sequencer
`timescale 1ns/10ps
module testbench;
  localparam int TICK = 4;
  localparam int TICKS = 40;
  logic clk = 1'b0;
  logic rst_n;
  logic in_valid, in_ovp, usb_valid, usb_ovp, dev_en;
  logic [1:0] ce;
  logic [2:0] usel;
  logic bat_conn, present, above_pres, v3v5, rech, above_tgt, over_lim;
  logic below_term, short_hit, path_loop, supp_req;
  logic [2:0] slow;
  logic buck_en, fet_on, rail_off, chg_on, half_cur, tgt_red, sink_en, src_en;
  logic sel_in, sel_usb, droop_hi, term_en, gate, done, fault;
  logic [11:0] lim_ma;
  int num_errors = 0;
  int n_tests = 0;
  int cyc_cnt = 0;

  chgseq_top #(.TERM_CYC(8), .DETECT_CYC(6), .SHORT_CYC(5), .TICK_CYC(TICK), .SAFETY_TICKS(TICKS)) i_chgseq_top (
    .CLK(clk), .RESET_N(rst_n), .IN_VALID(in_valid), .IN_OVP(in_ovp), .USB_VALID(usb_valid),
    .USB_OVP(usb_ovp), .DEVICE_EN(dev_en), .CHARGE_SELECT_A_N(ce[1]), .CHARGE_SELECT_B_N(ce[0]),
    .USB_LIMIT_SEL0(usel[0]), .USB_LIMIT_SEL1(usel[1]), .USB_LIMIT_SEL2(usel[2]),
    .BAT_CONNECTED(bat_conn), .BAT_ABOVE_PRESENCE(above_pres), .BAT_ABOVE_3V5(v3v5),
    .BAT_ABOVE_RECHARGE(rech), .BAT_ABOVE_TARGET(above_tgt), .BAT_OVER_LIMIT(over_lim),
    .BAT_BELOW_SHORT(slow[0]), .CHG_BELOW_TERM(below_term), .SHORT_LIMIT_HIT(short_hit),
    .PATH_LOOP_ACTIVE(path_loop), .SUPPLEMENT_REQ(supp_req), .INPUT_LIMIT_ACTIVE(slow[1]),
    .THERMAL_REG_ACTIVE(1'b0), .THERMAL_SHUTDOWN(1'b0), .THERM_WARM_COLD(slow[2]),
    .BUCK_EN(buck_en), .BAT_FET_ON(fet_on), .RAIL_FET_OFF_REG(rail_off), .CHARGE_ON(chg_on),
    .HALF_CURRENT(half_cur), .TARGET_REDUCED(tgt_red), .PRESENCE_SINK_EN(sink_en),
    .PRESENCE_SOURCE_EN(src_en), .SELECT_IN(sel_in), .SELECT_USB(sel_usb), .USB_LIMIT_MA(lim_ma),
    .USB_DROOP_HIGH(droop_hi), .TERM_ENABLED(term_en), .DISCHARGE_GATE_DRIVE(gate),
    .CHARGE_DONE(done), .TIMER_FAULT(fault));

  chgseq_battery_model i_chgseq_battery_model (.clk(clk), .rst_n(rst_n), .present(present),
    .sink_en(sink_en), .source_en(src_en), .above(above_pres));

  // 25 MHz clock
  always #20 clk = ~clk;

  // hang guard, well above the roughly 1200 cycles the run needs
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 4000) begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish;
    end
  end

  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %b expected %b", $time, got, exp);
    end
  endtask : chk

  task tally_and_finish;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // selector toggle through suspend restarts charging and the timer
  task resume;
    ce = 2'h3;
    cyc(3);
    ce = 2'h0;
    cyc(3);
  endtask : resume

  task t_decode;
    logic [11:0] lim [8];
    logic [7:0] dr;
    lim = '{12'h064, 12'h1f4, 12'h5dc, 12'h000, 12'h096, 12'h384, 12'h320, 12'h000};
    dr = 8'h66;
    usb_valid = 1'b1;
    for (int c = 0; c < 8; c++) begin
      usel = 3'(c);
      cyc(3);
      chk(lim_ma === lim[c], 1'b1);
      chk(droop_hi, dr[c]);
      chk(buck_en, usel[1:0] != 2'h3);
      chk(term_en, usel != 3'h0);
      chk(gate, usel == 3'h7);
    end
  endtask : t_decode

  task t_inputs;
    in_valid = 1'b1;
    usel = 3'h1;
    cyc(3);
    chk(sel_in, 1'b1);
    chk(sel_usb, 1'b0);
    chk(buck_en, 1'b1);
    in_ovp = 1'b1;
    cyc(3);
    chk(sel_usb, 1'b1);
    chk(gate, 1'b0);
    dev_en = 1'b0;
    cyc(3);
    chk(buck_en, 1'b0);
    {in_ovp, dev_en} = 2'h1;
    cyc(3);
  endtask : t_inputs

  // order 11, 00, 01, 10 so the first step suspends and the second is a resume
  task t_sel;
    for (int c = 3; c < 7; c++) begin
      ce = 2'(c);
      cyc(3);
      chk(half_cur, ce == 2'h1);
      chk(tgt_red, ce == 2'h2);
      chk(chg_on, ce != 2'h3);
    end
    ce = 2'h0;
  endtask : t_sel

  task t_fet;
    resume;
    v3v5 = 1'b1;
    cyc(3);
    chk(fet_on, 1'b1);
    above_tgt = 1'b1;
    cyc(3);
    chk(fet_on, 1'b0);
    chk(rail_off, 1'b1);
    {v3v5, above_tgt, supp_req} = 3'h1;
    cyc(3);
    chk(fet_on, 1'b1);
    {supp_req, over_lim} = 2'h1;
    cyc(3);
    chk(fet_on, 1'b1);
    chk(buck_en, 1'b0);
    over_lim = 1'b0;
  endtask : t_fet

  task t_detect;
    resume;
    {present, rech, below_term} = 3'h3;
    repeat (40) if (sink_en !== 1'b1) cyc(1);
    chk(sink_en, 1'b1);
    repeat (30) if (src_en !== 1'b1) cyc(1);
    chk(src_en, 1'b1);
    repeat (30) if (sink_en !== 1'b1) cyc(1);
    chk(sink_en, 1'b1);
    present = 1'b1;
    repeat (30) if (done !== 1'b1) cyc(1);
    chk(done, 1'b1);
    chk(chg_on, 1'b0);
    {rech, below_term} = 2'h0;
    cyc(3);
  endtask : t_detect

  task t_noterm;
    logic seen;
    seen = 1'b0;
    resume;
    usel = 3'h0;
    {rech, below_term} = 2'h3;
    repeat (40) begin
      cyc(1);
      seen = seen | sink_en;
    end
    chk(seen, 1'b0);
    chk(term_en, 1'b0);
    usel = 3'h1;
    {rech, below_term} = 2'h0;
  endtask : t_noterm

  task t_safety;
    resume;
    cyc(TICK * TICKS - 20);
    chk(fault, 1'b0);
    repeat (40) if (fault !== 1'b1) cyc(1);
    chk(fault, 1'b1);
    v3v5 = 1'b1;
    cyc(3);
    chk(fet_on, 1'b0);
    path_loop = 1'b1;
    resume;
    chk(fault, 1'b0);
    cyc(2 * TICK * TICKS - 30);
    chk(fault, 1'b0);
    repeat (60) if (fault !== 1'b1) cyc(1);
    chk(fault, 1'b1);
    {path_loop, bat_conn} = 2'h0;
    cyc(3);
    bat_conn = 1'b1;
    cyc(4);
    chk(fault, 1'b0);
    chk(chg_on, 1'b1);
  endtask : t_safety

  // each of the three slow inputs alone must outlast the full-rate timeout
  task t_slow;
    for (int c = 0; c < 3; c++) begin
      slow = 3'(1 << c);
      resume;
      cyc(TICK * TICKS + 20);
      chk(fault, 1'b0);
      slow = 3'h0;
    end
  endtask : t_slow

  task t_short;
    {in_valid, usb_valid} = 2'h0;
    cyc(3);
    chk(gate, 1'b1);
    chk(fet_on, 1'b1);
    short_hit = 1'b1;
    cyc(1);
    short_hit = 1'b0;
    cyc(2);
    chk(fet_on, 1'b0);
    cyc(8);
    chk(fet_on, 1'b1);
  endtask : t_short

  initial begin
    rst_n = 1'b0;
    {in_valid, in_ovp, usb_valid, usb_ovp, dev_en} = 5'h01;
    ce = 2'h0;
    usel = 3'h1;
    {bat_conn, present, v3v5, rech, above_tgt, over_lim} = 6'h30;
    {below_term, short_hit, path_loop, supp_req} = 4'h0;
    slow = 3'h0;
    cyc(4);
    rst_n = 1'b1;
    cyc(2);
    t_decode;
    t_inputs;
    t_sel;
    t_fet;
    t_detect;
    t_noterm;
    t_slow;
    t_safety;
    t_short;
    tally_and_finish;
  end
endmodule : testbench

bind chgseq_top chgseq_properties #(.TERM_CYC(TERM_CYC), .DETECT_CYC(DETECT_CYC), .SHORT_CYC(SHORT_CYC),
  .TICK_CYC(TICK_CYC), .SAFETY_TICKS(SAFETY_TICKS)) i_chgseq_properties (.*);
